/* sfcd_params.svh */
// sfcd host controller constants: opcodes, lengths, timing
//
// Contract
// - identification read 9E/9Fh only in extended, 1-20 bytes; AFh in dual/quad, 1-3 bytes.
// - no-address class takes no address bytes and no dummy cycles.
// - addressed class takes three address bytes then data, no dummy cycles.
// - fast reads take three address bytes, dummy 8, 10 in quad, or user value.
// - register writes, programs, erases, suspend/resume need a prior write enable 06h.
// - dual output fast read 3Bh allowed in extended and dual, streams while clocked.
// - quad output fast read 6Bh allowed in extended and quad, streams until deselect.
// - quad I/O fast read EBh allowed in extended and quad only.
// - quad input fast program 32h in extended and quad, 1 to 256 bytes.
// - dual input fast program A2h in extended and dual, 1 to 256 bytes.
`ifndef SFCD_PARAMS_SVH
`define SFCD_PARAMS_SVH
`define SFCD_OP_RDID_A    8'h9E
`define SFCD_OP_RDID_B    8'h9F
`define SFCD_OP_MIO_RDID  8'hAF
`define SFCD_OP_RD_DISC   8'h5A
`define SFCD_OP_READ      8'h03
`define SFCD_OP_FREAD     8'h0B
`define SFCD_OP_DOFR      8'h3B
`define SFCD_OP_DIOFR     8'hBB
`define SFCD_OP_QOFR      8'h6B
`define SFCD_OP_QIOFR     8'hEB
`define SFCD_OP_WR_EN     8'h06
`define SFCD_OP_WR_DIS    8'h04
`define SFCD_OP_RD_STAT   8'h05
`define SFCD_OP_WR_STAT   8'h01
`define SFCD_OP_RD_LOCK   8'hE8
`define SFCD_OP_WR_LOCK   8'hE5
`define SFCD_OP_RD_FLAG   8'h70
`define SFCD_OP_CLR_FLAG  8'h50
`define SFCD_OP_RD_NVCFG  8'hB5
`define SFCD_OP_WR_NVCFG  8'hB1
`define SFCD_OP_RD_VCFG   8'h85
`define SFCD_OP_WR_VCFG   8'h81
`define SFCD_OP_RD_EVCFG  8'h65
`define SFCD_OP_WR_EVCFG  8'h61
`define SFCD_OP_PP        8'h02
`define SFCD_OP_DIFP      8'hA2
`define SFCD_OP_XDIFP     8'hD2
`define SFCD_OP_QIFP      8'h32
`define SFCD_OP_XQIFP     8'h12
`define SFCD_OP_SSE       8'h20
`define SFCD_OP_SE        8'hD8
`define SFCD_OP_BE        8'hC7
`define SFCD_OP_RESUME    8'h7A
`define SFCD_OP_SUSPEND   8'h75
`define SFCD_OP_RD_OTP    8'h4B
`define SFCD_OP_PG_OTP    8'h42
`define SFCD_LEN_ID       16'h0014
`define SFCD_LEN_MIO_ID   16'h0003
`define SFCD_LEN_PAGE     16'h0100
`define SFCD_LEN_OTP      16'h0040
`define SFCD_LEN_NVCFG    16'h0002
`define SFCD_LEN_ONE      16'h0001
`define SFCD_LEN_STREAM   16'hFFFF
`define SFCD_DUMMY_DEF    5'h08
`define SFCD_DUMMY_QUAD   5'h0A
`define SFCD_ADDR_BITS    6'h18
`define SFCD_BYTE_BITS    6'h08
`define SFCD_DIV_RISE     3'h3
`define SFCD_DIV_LAST     3'h7
`endif

/* sfcd_pkg.sv */
// sfcd host controller shared types
package sfcd_pkg;
  typedef enum logic [1:0] {
    SFCD_EXT,
    SFCD_DUAL,
    SFCD_QUAD
  } sfcd_proto_t;
  typedef enum logic [2:0] {
    SFCD_IDLE,
    SFCD_OPC,
    SFCD_ADDR,
    SFCD_DUMMY,
    SFCD_DATA,
    SFCD_END
  } sfcd_state_t;
  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [15:0] len;
  } sfcd_req_t;
  typedef struct packed {
    logic        ok;
    logic        has_addr;
    logic        fast;
    logic        rd;
    logic        wr;
    logic        we;
    logic [2:0]  olanes;
    logic [2:0]  alanes;
    logic [2:0]  dlanes;
    logic [15:0] maxlen;
  } sfcd_info_t;
endpackage

/* sfcd_host.sv */
// sfcd host controller: drives a multi-I/O serial flash over chip select, clock and DQ
`timescale 1ns/1ps
`include "sfcd_params.svh"
module sfcd_host (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic [1:0]        evcr_proto_i,
  input  wire logic [4:0]        dummy_cfg_i,
  input  wire sfcd_pkg::sfcd_req_t req_i,
  input  wire logic              req_valid_i,
  output logic                   req_ready_o,
  output logic                   done_o,
  output logic                   refused_o,
  output logic                   wel_o,
  input  wire logic [7:0]        wr_data_i,
  input  wire logic              wr_valid_i,
  output logic                   wr_ready_o,
  output logic [7:0]             rd_data_o,
  output logic                   rd_valid_o,
  input  wire logic              rd_ready_i,
  output logic                   cs_n_o,
  output logic                   sclk_o,
  output logic [3:0]             dq_o,
  output logic [3:0]             dq_oe_o,
  input  wire logic [3:0]        dq_i
);

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // protocol select
  function automatic sfcd_pkg::sfcd_proto_t sfcd_proto(input logic [1:0] b);
    sfcd_pkg::sfcd_proto_t p;
    p = sfcd_pkg::SFCD_QUAD;
    if (b == 2'h3) begin
      p = sfcd_pkg::SFCD_EXT;
    end else if (b == 2'h2) begin
      p = sfcd_pkg::SFCD_DUAL;
    end
    return p;
  endfunction

  function automatic sfcd_pkg::sfcd_info_t sfcd_decode(input logic [7:0] op,
                                                       input sfcd_pkg::sfcd_proto_t p);
    sfcd_pkg::sfcd_info_t d;
    logic       known;
    logic       in_ext;
    logic       in_dual;
    logic       in_quad;
    logic [2:0] xa;
    logic [2:0] xd;
    logic [2:0] w;
    d = '0;
    known = 1'b1;
    in_ext = 1'b1;
    in_dual = 1'b1;
    in_quad = 1'b1;
    xa = 3'h1;
    xd = 3'h1;
    case (op)
      `SFCD_OP_RDID_A, `SFCD_OP_RDID_B: begin
        in_dual = 1'b0; in_quad = 1'b0; d.rd = 1'b1; d.maxlen = `SFCD_LEN_ID;
      end
      `SFCD_OP_MIO_RDID: begin
        in_ext = 1'b0; d.rd = 1'b1; d.maxlen = `SFCD_LEN_MIO_ID;
      end
      `SFCD_OP_READ: begin
        in_dual = 1'b0; in_quad = 1'b0; d.rd = 1'b1; d.has_addr = 1'b1; d.maxlen = `SFCD_LEN_STREAM;
      end
      `SFCD_OP_FREAD, `SFCD_OP_RD_DISC, `SFCD_OP_RD_OTP: begin
        d.rd = 1'b1; d.has_addr = 1'b1; d.fast = 1'b1;
        d.maxlen = (op == `SFCD_OP_RD_OTP) ? `SFCD_LEN_OTP : `SFCD_LEN_STREAM;
      end
      // dual output and dual I/O fast read
      `SFCD_OP_DOFR, `SFCD_OP_DIOFR: begin
        in_quad = 1'b0; d.rd = 1'b1; d.has_addr = 1'b1; d.fast = 1'b1; d.maxlen = `SFCD_LEN_STREAM;
        xd = 3'h2; xa = (op == `SFCD_OP_DIOFR) ? 3'h2 : 3'h1;
      end
      // quad output and quad I/O fast read
      `SFCD_OP_QOFR, `SFCD_OP_QIOFR: begin
        in_dual = 1'b0; d.rd = 1'b1; d.has_addr = 1'b1; d.fast = 1'b1; d.maxlen = `SFCD_LEN_STREAM;
        xd = 3'h4; xa = (op == `SFCD_OP_QIOFR) ? 3'h4 : 3'h1;
      end
      `SFCD_OP_WR_EN, `SFCD_OP_WR_DIS, `SFCD_OP_CLR_FLAG: ;
      `SFCD_OP_BE, `SFCD_OP_RESUME, `SFCD_OP_SUSPEND: d.we = 1'b1;
      `SFCD_OP_RD_STAT, `SFCD_OP_RD_FLAG, `SFCD_OP_RD_VCFG, `SFCD_OP_RD_EVCFG: begin
        d.rd = 1'b1; d.maxlen = `SFCD_LEN_STREAM;
      end
      `SFCD_OP_RD_NVCFG: begin
        d.rd = 1'b1; d.maxlen = `SFCD_LEN_NVCFG;
      end
      `SFCD_OP_RD_LOCK: begin
        d.rd = 1'b1; d.has_addr = 1'b1; d.maxlen = `SFCD_LEN_STREAM;
      end
      `SFCD_OP_WR_STAT, `SFCD_OP_WR_VCFG, `SFCD_OP_WR_EVCFG: begin
        d.wr = 1'b1; d.we = 1'b1; d.maxlen = `SFCD_LEN_ONE;
      end
      `SFCD_OP_WR_NVCFG: begin
        d.wr = 1'b1; d.we = 1'b1; d.maxlen = `SFCD_LEN_NVCFG;
      end
      `SFCD_OP_WR_LOCK: begin
        d.wr = 1'b1; d.we = 1'b1; d.has_addr = 1'b1; d.maxlen = `SFCD_LEN_ONE;
      end
      `SFCD_OP_PP, `SFCD_OP_PG_OTP: begin
        d.wr = 1'b1; d.we = 1'b1; d.has_addr = 1'b1;
        d.maxlen = (op == `SFCD_OP_PG_OTP) ? `SFCD_LEN_OTP : `SFCD_LEN_PAGE;
      end
      `SFCD_OP_DIFP, `SFCD_OP_XDIFP: begin
        in_quad = 1'b0; d.wr = 1'b1; d.we = 1'b1; d.has_addr = 1'b1; d.maxlen = `SFCD_LEN_PAGE;
        xd = 3'h2; xa = (op == `SFCD_OP_XDIFP) ? 3'h2 : 3'h1;
      end
      `SFCD_OP_QIFP, `SFCD_OP_XQIFP: begin
        in_dual = 1'b0; d.wr = 1'b1; d.we = 1'b1; d.has_addr = 1'b1; d.maxlen = `SFCD_LEN_PAGE;
        xd = 3'h4; xa = (op == `SFCD_OP_XQIFP) ? 3'h4 : 3'h1;
      end
      `SFCD_OP_SSE, `SFCD_OP_SE: begin
        d.we = 1'b1; d.has_addr = 1'b1;
      end
      default: known = 1'b0;
    endcase
    w = (p == sfcd_pkg::SFCD_QUAD) ? 3'h4 : (p == sfcd_pkg::SFCD_DUAL) ? 3'h2 : 3'h1;
    d.olanes = w;
    d.alanes = (p == sfcd_pkg::SFCD_EXT) ? xa : w;
    d.dlanes = (p == sfcd_pkg::SFCD_EXT) ? xd : w;
    d.ok = known && ((p == sfcd_pkg::SFCD_EXT) ? in_ext : (p == sfcd_pkg::SFCD_DUAL) ? in_dual : in_quad);
    return d;
  endfunction

  function automatic logic [5:0] sfcd_beats(input logic [5:0] bits, input logic [2:0] w);
    return (w == 3'h4) ? (bits >> 2) : (w == 3'h2) ? (bits >> 1) : bits;
  endfunction

  function automatic logic [3:0] sfcd_mask(input logic [2:0] w);
    return (w == 3'h4) ? 4'hF : (w == 3'h2) ? 4'h3 : 4'h1;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  sfcd_pkg::sfcd_state_t st_r, st_nxt;
  sfcd_pkg::sfcd_info_t  info_r, dinfo;
  logic [7:0]  op_r;
  logic [23:0] addr_r;
  logic [23:0] sh_r, sh_nxt;
  logic [15:0] cnt_r;
  logic [5:0]  bl_r, bl_nxt;
  logic [4:0]  dum_r;
  logic [2:0]  div_r;
  logic [7:0]  rx_r, rx_nxt;
  logic [3:0]  dq_m_r, dq_s_r;
  logic        cs_n_r, sclk_r, wel_r, done_r, refused_r;
  logic [3:0]  dq_o_r, dq_oe_r;
  logic [2:0]  w_cur, w_nxt;
  logic        active, phase_end, load_wr, push_rd, stall, adv, accept, len_ok, drive_nxt;
  logic [7:0]  fifo_mem [2];
  logic        fifo_wp_r, fifo_rp_r;
  logic [1:0]  fifo_cnt_r;
  logic        fifo_in_rdy, fifo_pop;

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dq_m_r <= 4'h0;
      dq_s_r <= 4'h0;
    end else if (ce_i) begin
      dq_m_r <= dq_i;
      dq_s_r <= dq_m_r;
    end
  end

  // ---------------------------------------------------------------
  // request check and beat control
  // ---------------------------------------------------------------
  assign dinfo  = sfcd_decode(req_i.opcode, sfcd_proto(evcr_proto_i));
  assign len_ok = (dinfo.maxlen == 16'h0000) ? (req_i.len == 16'h0000)
                : ((req_i.len != 16'h0000) && (req_i.len <= dinfo.maxlen));
  assign accept = dinfo.ok && len_ok && (!dinfo.we || wel_r);
  assign req_ready_o = ce_i && (st_r == sfcd_pkg::SFCD_IDLE);
  assign active = (st_r != sfcd_pkg::SFCD_IDLE) && (st_r != sfcd_pkg::SFCD_END);

  always_comb begin
    case (st_r)
      sfcd_pkg::SFCD_OPC:  w_cur = info_r.olanes;
      sfcd_pkg::SFCD_ADDR: w_cur = info_r.alanes;
      sfcd_pkg::SFCD_DATA: w_cur = info_r.dlanes;
      default:             w_cur = 3'h1;
    endcase
  end

  assign phase_end = (bl_r == 6'h01);

  always_comb begin
    st_nxt = st_r;
    if (phase_end) begin
      case (st_r)
        sfcd_pkg::SFCD_OPC:   st_nxt = info_r.has_addr ? sfcd_pkg::SFCD_ADDR
                                     : (cnt_r == 16'h0000) ? sfcd_pkg::SFCD_END : sfcd_pkg::SFCD_DATA;
        sfcd_pkg::SFCD_ADDR:  st_nxt = (info_r.fast && dum_r != 5'h00) ? sfcd_pkg::SFCD_DUMMY
                                     : (cnt_r == 16'h0000) ? sfcd_pkg::SFCD_END : sfcd_pkg::SFCD_DATA;
        sfcd_pkg::SFCD_DUMMY: st_nxt = sfcd_pkg::SFCD_DATA;
        sfcd_pkg::SFCD_DATA:  st_nxt = (cnt_r == 16'h0001) ? sfcd_pkg::SFCD_END : sfcd_pkg::SFCD_DATA;
        default:              st_nxt = st_r;
      endcase
    end
  end

  always_comb begin
    case (st_nxt)
      sfcd_pkg::SFCD_OPC:  w_nxt = info_r.olanes;
      sfcd_pkg::SFCD_ADDR: w_nxt = info_r.alanes;
      sfcd_pkg::SFCD_DATA: w_nxt = info_r.dlanes;
      default:             w_nxt = 3'h1;
    endcase
  end

  assign load_wr = phase_end && (st_nxt == sfcd_pkg::SFCD_DATA) && info_r.wr;
  assign push_rd = phase_end && (st_r == sfcd_pkg::SFCD_DATA) && info_r.rd;
  // clock held high while data is short or buffer is full
  assign stall = (div_r == `SFCD_DIV_LAST) && ((load_wr && !wr_valid_i) || (push_rd && !fifo_in_rdy));
  assign adv = ce_i && active && (div_r == `SFCD_DIV_LAST) && !stall;
  assign wr_ready_o = adv && load_wr;
  assign drive_nxt = (st_nxt == sfcd_pkg::SFCD_OPC) || (st_nxt == sfcd_pkg::SFCD_ADDR)
                   || ((st_nxt == sfcd_pkg::SFCD_DATA) && info_r.wr);

  always_comb begin
    sh_nxt = sh_r << w_cur;
    bl_nxt = bl_r - 6'h01;
    if (phase_end) begin
      case (st_nxt)
        sfcd_pkg::SFCD_ADDR:  begin sh_nxt = addr_r; bl_nxt = sfcd_beats(`SFCD_ADDR_BITS, info_r.alanes); end
        sfcd_pkg::SFCD_DUMMY: begin sh_nxt = 24'h000000; bl_nxt = {1'b0, dum_r}; end
        sfcd_pkg::SFCD_DATA:  begin
          sh_nxt = info_r.wr ? {wr_data_i, 16'h0000} : 24'h000000;
          bl_nxt = sfcd_beats(`SFCD_BYTE_BITS, info_r.dlanes);
        end
        default:              begin sh_nxt = 24'h000000; bl_nxt = 6'h00; end
      endcase
    end
  end

  always_comb begin
    case (w_cur)
      3'h4:    rx_nxt = {rx_r[3:0], dq_s_r};
      3'h2:    rx_nxt = {rx_r[5:0], dq_s_r[1:0]};
      default: rx_nxt = {rx_r[6:0], dq_s_r[1]};
    endcase
  end

  // ---------------------------------------------------------------
  // link engine
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r    <= sfcd_pkg::SFCD_IDLE;
      info_r  <= '0;
      op_r    <= 8'h00;
      addr_r  <= 24'h000000;
      sh_r    <= 24'h000000;
      cnt_r   <= 16'h0000;
      bl_r    <= 6'h00;
      dum_r   <= 5'h00;
      div_r   <= 3'h0;
      rx_r    <= 8'h00;
      cs_n_r  <= 1'b1;
      sclk_r  <= 1'b0;
      dq_o_r  <= 4'h0;
      dq_oe_r <= 4'h0;
    end else if (ce_i) begin
      case (st_r)
        sfcd_pkg::SFCD_IDLE: begin
          div_r <= 3'h0;
          if (req_valid_i && accept) begin
            info_r  <= dinfo;
            op_r    <= req_i.opcode;
            addr_r  <= req_i.addr;
            cnt_r   <= req_i.len;
            dum_r   <= (dummy_cfg_i != 5'h00) ? dummy_cfg_i
                     : (sfcd_proto(evcr_proto_i) == sfcd_pkg::SFCD_QUAD) ? `SFCD_DUMMY_QUAD : `SFCD_DUMMY_DEF;
            sh_r    <= {req_i.opcode, 16'h0000};
            bl_r    <= sfcd_beats(`SFCD_BYTE_BITS, dinfo.olanes);
            cs_n_r  <= 1'b0;
            dq_o_r  <= req_i.opcode[7:4] >> (3'h4 - dinfo.olanes);
            dq_oe_r <= sfcd_mask(dinfo.olanes);
            st_r    <= sfcd_pkg::SFCD_OPC;
          end
        end
        sfcd_pkg::SFCD_END: begin
          div_r <= div_r + 3'h1;
          if (div_r == `SFCD_DIV_LAST) begin
            st_r <= sfcd_pkg::SFCD_IDLE;
          end
        end
        default: begin
          if (!stall) begin
            div_r <= div_r + 3'h1;
          end
          if (div_r == `SFCD_DIV_RISE) begin
            sclk_r <= 1'b1;
          end
          if (adv) begin
            sclk_r <= 1'b0;
            st_r   <= st_nxt;
            sh_r   <= sh_nxt;
            bl_r   <= bl_nxt;
            rx_r   <= rx_nxt;
            if (phase_end && (st_r == sfcd_pkg::SFCD_DATA)) begin
              cnt_r <= cnt_r - 16'h0001;
            end
            dq_o_r  <= drive_nxt ? (sh_nxt[23:20] >> (3'h4 - w_nxt)) : 4'h0;
            dq_oe_r <= drive_nxt ? sfcd_mask(w_nxt) : 4'h0;
            if (st_nxt == sfcd_pkg::SFCD_END) begin
              cs_n_r <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // write enable latch mirror and result pulses
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wel_r     <= 1'b0;
      done_r    <= 1'b0;
      refused_r <= 1'b0;
    end else if (ce_i) begin
      done_r    <= (st_r == sfcd_pkg::SFCD_END) && (div_r == `SFCD_DIV_LAST);
      refused_r <= (st_r == sfcd_pkg::SFCD_IDLE) && req_valid_i && !accept;
      // latch set by 06h, spent by write class
      if ((st_r == sfcd_pkg::SFCD_END) && (div_r == `SFCD_DIV_LAST)) begin
        if (op_r == `SFCD_OP_WR_EN) begin
          wel_r <= 1'b1;
        end else if ((op_r == `SFCD_OP_WR_DIS) || info_r.we) begin
          wel_r <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // two-entry read buffer
  // ---------------------------------------------------------------
  assign fifo_in_rdy = (fifo_cnt_r != 2'h2);
  assign fifo_pop    = ce_i && rd_ready_i && (fifo_cnt_r != 2'h0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fifo_wp_r   <= 1'b0;
      fifo_rp_r   <= 1'b0;
      fifo_cnt_r  <= 2'h0;
      fifo_mem[0] <= 8'h00;
      fifo_mem[1] <= 8'h00;
    end else if (ce_i) begin
      if (adv && push_rd) begin
        fifo_mem[fifo_wp_r] <= rx_nxt;
        fifo_wp_r <= ~fifo_wp_r;
      end
      if (fifo_pop) begin
        fifo_rp_r <= ~fifo_rp_r;
      end
      fifo_cnt_r <= fifo_cnt_r + {1'b0, adv && push_rd} - {1'b0, fifo_pop};
    end
  end

  assign rd_data_o  = fifo_mem[fifo_rp_r];
  assign rd_valid_o = (fifo_cnt_r != 2'h0);
  assign cs_n_o     = cs_n_r;
  assign sclk_o     = sclk_r;
  assign dq_o       = dq_o_r;
  assign dq_oe_o    = dq_oe_r;
  assign wel_o      = wel_r;
  assign done_o     = done_r;
  assign refused_o  = refused_r;

endmodule

/* sfcd_host_monitor.sv */
// sfcd host checker: port-level command rules
`timescale 1ns/1ps
module sfcd_host_monitor (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  input  wire logic [1:0]          evcr_proto_i,
  input  wire sfcd_pkg::sfcd_req_t req_i,
  input  wire logic                req_valid_i,
  input  wire logic                req_ready_o,
  input  wire logic                done_o,
  input  wire logic                refused_o,
  input  wire logic                wel_o,
  input  wire logic                cs_n_o,
  input  wire logic                sclk_o,
  input  wire logic [3:0]          dq_oe_o
);
  logic       take;
  logic [7:0] op;
  assign take = req_valid_i && req_ready_o && ce_i;
  assign op   = req_i.opcode;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_reset_idle: assert property ($fell(rst_i) |-> cs_n_o && !sclk_o && dq_oe_o == 4'h0 && !wel_o)
    else $error("bus not idle after reset");
  a_sclk_idle: assert property (cs_n_o |-> !sclk_o)
    else $error("serial clock high while deselected");
  a_refuse_quiet: assert property (refused_o |-> cs_n_o && $past(cs_n_o))
    else $error("pin activity on refused request");
  a_done_gap: assert property (done_o |-> cs_n_o && $past(cs_n_o, 7) && !refused_o)
    else $error("done without deselect gap");
  a_id_ext_only: assert property (take && op == 8'h9F && evcr_proto_i != 2'h3 |-> ##[1:2] refused_o)
    else $error("id read accepted outside extended");
  a_quad_no_3b: assert property (take && op == 8'h3B && !evcr_proto_i[1] |-> ##[1:2] refused_o)
    else $error("dual output read accepted in quad");
  a_dual_no_6b: assert property (take && op == 8'h6B && evcr_proto_i == 2'h2 |-> ##[1:2] refused_o)
    else $error("quad output read accepted in dual");
  a_dual_no_eb: assert property (take && op == 8'hEB && evcr_proto_i == 2'h2 |-> ##[1:2] refused_o)
    else $error("quad io read accepted in dual");
  a_wel_first: assert property (take && op == 8'h02 && !wel_o |-> ##[1:2] refused_o)
    else $error("program accepted without write enable");
  a_unknown_op: assert property (take && op == 8'hFF |-> ##[1:2] refused_o)
    else $error("unknown opcode accepted");
  a_flag_any: assert property (take && op == 8'h70 && req_i.len == 16'h0001 |-> ##[1:2] !cs_n_o)
    else $error("flag read not started");
  c_done: cover property (done_o);
  c_refused: cover property (refused_o);
  c_wel: cover property ($rose(wel_o));
endmodule

/* sfcd_flash_model.sv */
// sfcd flash device model: extended single-lane decode, flag register, write enable latch
`timescale 1ns/1ps
module sfcd_flash_model #(
  parameter logic [7:0] FLAG_INIT = 8'h82
) (
  input  wire logic       cs_n_i,
  input  wire logic       sclk_i,
  input  wire logic [4:0] dummy_i,
  input  wire logic [3:0] dq_i,
  output logic      [3:0] dq_o
);
  int          bits   = 0;
  int          hdr;
  logic [7:0]  opc    = 8'h00;
  logic [23:0] cap    = 24'h000000;
  logic [7:0]  flag_r = FLAG_INIT;
  logic        wel_r  = 1'b0;
  logic [7:0]  dat;
  initial dq_o = 4'h5;
  always_comb begin
    case (opc)
      8'h03, 8'hE8: hdr = 32;
      8'h0B:        hdr = 32 + ((dummy_i == 5'h00) ? 8 : int'(dummy_i));
      default:      hdr = 8;
    endcase
  end
  always @(posedge sclk_i) begin
    if (!cs_n_i) begin
      if (bits < 8) opc = {opc[6:0], dq_i[0]};
      else if (bits < 32) cap = {cap[22:0], dq_i[0]};
      bits = bits + 1;
    end
  end
  // data out on lane 1, flag register repeats
  always @(negedge sclk_i) begin
    if (!cs_n_i && bits >= hdr) begin
      dat = (opc == 8'h70) ? flag_r : 8'hA0 + 8'((bits - hdr) / 8);
      dq_o[1] = dat[7 - ((bits - hdr) % 8)];
    end else begin
      dq_o = ~dq_o;
    end
  end
  // latch and flag update at deselect, decode restarts
  always @(posedge cs_n_i) begin
    if (bits == 8 && opc == 8'h06) wel_r = 1'b1;
    if (bits == 8 && opc == 8'h04) wel_r = 1'b0;
    if (bits == 16 && opc == 8'h01) wel_r = 1'b0;
    if (bits == 8 && opc == 8'h50) flag_r = flag_r & 8'hC5;
    bits = 0;
    dq_o = ~dq_o;
  end
endmodule

/* sfcd_host_tb_top.sv */
// sfcd host testbench: device model, refusal table, reads, writes, flag register
`timescale 1ns/1ps
module sfcd_host_tb_top;
  logic                clk_i        = 1'b0;
  logic                rst_i        = 1'b1;
  logic                ce_i         = 1'b1;
  logic [1:0]          evcr_proto_i = 2'h3;
  logic [4:0]          dummy_cfg_i  = 5'h00;
  sfcd_pkg::sfcd_req_t req_i        = '0;
  logic                req_valid_i  = 1'b0;
  logic [7:0]          wr_data_i    = 8'h5C;
  logic                wr_valid_i   = 1'b1;
  logic                rd_ready_i   = 1'b1;
  logic                req_ready_o, done_o, refused_o, wel_o, wr_ready_o, rd_valid_o, cs_n_o, sclk_o;
  logic [7:0]          rd_data_o;
  logic [3:0]          dq_o, dq_oe_o, dq_i, dev_dq;
  logic [7:0]          rdq[$];
  logic [25:0]         tbl[12];
  int                  error_cnt    = 0;
  int                  n_tests      = 0;
  int                  n_wr         = 0;
  assign dq_i = (dq_oe_o & dq_o) | (~dq_oe_o & dev_dq);
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1) rdq.push_back(rd_data_o);
  always @(posedge clk_i) if (wr_ready_o === 1'b1) n_wr++;
  sfcd_host u_dut (.clk_i, .rst_i, .ce_i, .evcr_proto_i, .dummy_cfg_i, .req_i, .req_valid_i, .req_ready_o,
    .done_o, .refused_o, .wel_o, .wr_data_i, .wr_valid_i, .wr_ready_o, .rd_data_o, .rd_valid_o, .rd_ready_i,
    .cs_n_o, .sclk_o, .dq_o, .dq_oe_o, .dq_i);
  sfcd_flash_model u_dev (.cs_n_i(cs_n_o), .sclk_i(sclk_o), .dummy_i(dummy_cfg_i), .dq_i(dq_i), .dq_o(dev_dq));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic print_verdict;
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic run(input logic [1:0] pr, input logic [7:0] op, input logic [23:0] ad,
                     input logic [15:0] ln, input logic rf);
    int n;
    @(negedge clk_i);
    rdq.delete();
    evcr_proto_i = pr;
    req_i = '{opcode: op, addr: ad, len: ln};
    req_valid_i = 1'b1;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 100) begin @(negedge clk_i); n++; end
    @(negedge clk_i);
    req_valid_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && refused_o !== 1'b1 && n < 30000) begin @(negedge clk_i); n++; end
    chk("outcome", {22'h0, rf, !rf}, {22'h0, refused_o, done_o});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("cs_n_o", 1, cs_n_o);
    chk("wel_o", 0, wel_o);
    ce_i = 1'b0;
    @(negedge clk_i);
    chk("req_ready_o", 0, req_ready_o);
    ce_i = 1'b1;
  endtask
  task automatic t_refuse;
    tbl = '{{2'h3, 8'hAF, 16'h0001}, {2'h2, 8'h9F, 16'h0001}, {2'h3, 8'h9F, 16'h0015},
            {2'h2, 8'hAF, 16'h0004}, {2'h1, 8'h3B, 16'h0001}, {2'h2, 8'h6B, 16'h0001},
            {2'h2, 8'hEB, 16'h0001}, {2'h3, 8'h02, 16'h0001}, {2'h3, 8'hFF, 16'h0000},
            {2'h3, 8'h50, 16'h0001}, {2'h3, 8'h20, 16'h0000}, {2'h3, 8'h75, 16'h0000}};
    foreach (tbl[i]) run(tbl[i][25:24], tbl[i][23:16], 24'h0, tbl[i][15:0], 1'b1);
  endtask
  task automatic t_id_read;
    rd_ready_i = 1'b0;
    fork
      begin
        repeat (600) @(negedge clk_i);
        chk("stall_cs", 0, cs_n_o);
        chk("stall_valid", 1, rd_valid_o);
        rd_ready_i = 1'b1;
      end
    join_none
    run(2'h3, 8'h9F, 24'h0, 16'h0014, 1'b0);
    chk("id_count", 20, rdq.size());
    for (int i = 0; i < 20; i++) chk("id_byte", 8'hA0 + i, rdq[i]);
    chk("id_op", 8'h9F, u_dev.opc);
  endtask
  task automatic t_fast;
    for (int d = 0; d < 8; d += 4) begin
      dummy_cfg_i = 5'(d);
      run(2'h3, 8'h0B, 24'h123456, 16'h0002, 1'b0);
      chk("fast_addr", 24'h123456, u_dev.cap);
      chk("fast_data", 16'hA0A1, {rdq[0], rdq[1]});
    end
    dummy_cfg_i = 5'h00;
    run(2'h3, 8'h03, 24'h00A5C3, 16'h0001, 1'b0);
    chk("read_addr", 24'h00A5C3, u_dev.cap);
    chk("read_data", 8'hA0, rdq[0]);
  endtask
  task automatic t_wel;
    run(2'h3, 8'h06, 24'h0, 16'h0000, 1'b0);
    chk("wel_set", 2'h3, {wel_o, u_dev.wel_r});
    run(2'h2, 8'h32, 24'h0, 16'h0001, 1'b1);
    run(2'h3, 8'h32, 24'h0, 16'h0101, 1'b1);
    run(2'h1, 8'hA2, 24'h0, 16'h0001, 1'b1);
    wr_valid_i = 1'b0;
    fork
      begin
        repeat (300) @(negedge clk_i);
        wr_valid_i = 1'b1;
      end
    join_none
    run(2'h3, 8'h01, 24'h0, 16'h0001, 1'b0);
    chk("wr_byte", 8'h5C, u_dev.cap[7:0]);
    chk("wr_taken", 1, n_wr);
    chk("wel_clr", 2'h0, {wel_o, u_dev.wel_r});
  endtask
  task automatic t_flag;
    run(2'h3, 8'h70, 24'h0, 16'h0002, 1'b0);
    chk("flag_err", 16'h8282, {rdq[0], rdq[1]});
    run(2'h3, 8'h50, 24'h0, 16'h0000, 1'b0);
    run(2'h3, 8'h70, 24'h0, 16'h0001, 1'b0);
    chk("flag_clr", 8'h80, rdq[0]);
  endtask
  task automatic t_proto;
    run(2'h0, 8'h70, 24'h0, 16'h0001, 1'b0);
    chk("quad_cnt", 1, rdq.size());
    run(2'h2, 8'hAF, 24'h0, 16'h0003, 1'b0);
    chk("mio_cnt", 3, rdq.size());
    run(2'h2, 8'h3B, 24'h0, 16'h0001, 1'b0);
    run(2'h1, 8'h6B, 24'h0, 16'h0001, 1'b0);
  endtask
  initial begin
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    t_reset();
    t_refuse();
    t_id_read();
    t_fast();
    t_wel();
    t_flag();
    t_proto();
    print_verdict();
  end
  initial begin
    #3000000;
    error_cnt++;
    print_verdict();
  end
endmodule
bind sfcd_host sfcd_host_monitor u_mon (.clk_i, .rst_i, .ce_i, .evcr_proto_i, .req_i, .req_valid_i,
  .req_ready_o, .done_o, .refused_o, .wel_o, .cs_n_o, .sclk_o, .dq_oe_o);
